// ---- rtl/mcd_pkg.sv ----
// Purpose: Shared constants and carriers for the mode command data handler
// Assumes: 16-bit serial-bus words, 32-bit AXI4-Lite register access
// Notes: Register offsets are word indices; byte address is index times four
package mcd_pkg;

  localparam int MCD_WORD_W = 16;
  localparam int MCD_MEM_AW = 9;
  localparam int MCD_IDX_W = 10;
  localparam int MCD_AXI_AW = 12;

  // Register indices
  localparam logic [9:0] IDX_CFG1 = 10'h001;
  localparam logic [9:0] IDX_CFG2 = 10'h002;
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_LAST_CMD = 10'h004;
  localparam logic [9:0] IDX_SELFTEST0 = 10'h014;
  localparam logic [9:0] IDX_SELFTEST1 = 10'h015;
  localparam logic [9:0] IDX_MEM_BASE = 10'h200;

  // Configuration fields and reset values
  localparam int CFG1_SIMPL_BIT = 0;
  localparam int CFG1_UNDEF_BIT = 1;
  localparam int CFG2_ALT_BIT = 0;
  localparam int STAT_MSGERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam logic CFG_SIMPL_RST = 1'b0;
  localparam logic CFG_UNDEF_RST = 1'b0;
  localparam logic CFG_ALT_RST = 1'b0;
  localparam logic [15:0] SELFTEST_RST = 16'h0000;
  localparam logic [15:0] LAST_CMD_RST = 16'h0000;

  // Command word fields
  localparam int CMD_TR_BIT = 10;

  // Descriptor control word bits
  localparam int CTL_PP_EN_BIT = 0;
  localparam int CTL_PP_SEL_BIT = 1;
  localparam int CTL_DBAC_BIT = 2;
  localparam int CTL_BCAST_BIT = 3;

  // Message information word bits
  localparam int MI_BCAST_BIT = 15;
  localparam int MI_ERR_BIT = 14;
  localparam int MI_TR_BIT = 5;

  // Word offsets in descriptor and buffer
  localparam logic [8:0] DESC_PTR_OFS = 9'h001;
  localparam logic [8:0] BUF_INFO_OFS = 9'h000;
  localparam logic [8:0] BUF_TT_OFS = 9'h001;
  localparam logic [8:0] BUF_DATA_OFS = 9'h002;

  // Mode code values
  localparam logic [4:0] MC_DYN_BUS = 5'h00;
  localparam logic [4:0] MC_SYNC = 5'h01;
  localparam logic [4:0] MC_SELFTEST_INIT = 5'h03;
  localparam logic [4:0] MC_LAST_MAX_NODATA = 5'h0F;
  localparam logic [4:0] MC_VECTOR = 5'h10;
  localparam logic [4:0] MC_SYNC_DATA = 5'h11;
  localparam logic [4:0] last_command_report_code = 5'h12;
  localparam logic [4:0] selftest_word_report_code = 5'h13;
  localparam logic [4:0] MC_SEL_SHUT = 5'h14;
  localparam logic [4:0] MC_SEL_OVR = 5'h15;
  localparam logic [4:0] MC_RSVD_LO = 5'h16;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RESP = 7'h02,
    ST_RXW = 7'h04,
    ST_WINFO = 7'h08,
    ST_WTT = 7'h10,
    ST_WDATA = 7'h20,
    ST_WCTL = 7'h40
  } mcd_state_e;

  typedef struct packed {
    logic valid;
    logic bcast;
    logic illegal_bit;
    logic [15:0] word;
  } mcd_cmd_s;

  typedef struct packed {
    logic valid;
    logic send_status;
    logic send_data;
    logic msg_error;
  } mcd_resp_s;

endpackage : mcd_pkg

// ---- rtl/mcd_handler.sv ----
// Purpose: Mode command data word handler with AXI4-Lite configuration
// Assumes: cmd_i carries only mode commands; table bit supplied with the command
// Notes: Descriptor table and buffers live in the internal word memory
//
// Contract
// R1: Codes 0-15 carry no data; valid non-broadcast reply is status only.
// R2: Codes 16-31 carry one data word; receive takes it after the command.
// R3: Legal transmit codes 16-31 send status plus exactly one data word.
// R4: Standard mode keeps data words in indexed or ping-pong buffer per descriptor.
// R5: No circular buffering for mode commands; only indexed or ping-pong.
// R6: Simplified mode keeps data words inside the descriptor entries.
// R7: Transmit 1,3-15 broadcast ok; transmit 0,2 and receive 0-15 refused.
// R8: Receive 22-31 broadcast ok; transmit 22-31 refused as broadcast.
// R9: Receive 17,20,21 broadcast ok; transmit 16,18,19 and undefined refused.
// R10: Dynamic bus control is never honoured.
// R11: Undefined-invalid set ignores all 22 undefined codes fully.
// R12: Otherwise undefined codes answer in form with their data word.
// R13: Table bit one makes command illegal: error flag, status only.
// R14: Reserved codes follow their table bit; in-form 16-31 move data.
// R15: Host gives mode commands indexed or ping-pong buffers, single message.
// R16: Codes 0-15 update only info and time-tag words in buffer.
// R17: Receive 16-31 stores data, info and time-tag after message.
// R18: Most transmit 16-31 fetch data from descriptor's buffer location.
// R19: Code 18 transmits the last command word, not buffer data.
// R20: Code 19 transmits self-test word 0x14 or 0x15 per select bit.
// R21: After codes 18 and 19 the sent word is stored with info.
// R22: Undefined-invalid option resets low.
`timescale 1ns/1ps
module mcd_handler #(
  parameter int MEM_DEPTH = 512
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire mcd_pkg::mcd_cmd_s cmd_i,
  input wire logic [15:0] time_tag_i,
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_word_i,
  output logic rx_ready_o,
  output mcd_pkg::mcd_resp_s resp_o,
  output logic [15:0] tx_word_o,
  output logic tx_valid_o,
  output logic done_o,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mcd_pkg::*;

  typedef struct packed {
    mcd_state_e state;
    logic simpl;
    logic undef_inv;
    logic alt_sel;
    logic [15:0] selftest0;
    logic [15:0] selftest1;
    logic [15:0] last_cmd;
    logic msg_err;
    logic [4:0] code;
    logic tr;
    logic bcast;
    logic illegal;
    logic store_data;
    logic [15:0] data;
    logic [8:0] desc;
    logic [8:0] base;
    mcd_resp_s resp;
    logic [15:0] tx_word;
    logic tx_valid;
    logic done;
    logic aw_held;
    logic [9:0] aw_idx;
    logic w_held;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcd_st_s;

  mcd_st_s r_ff;
  mcd_st_s nxt_r;
  logic [15:0] mem_ff [MEM_DEPTH];
  logic mem_we;
  logic [8:0] mem_wa;
  logic [15:0] mem_wd;

  //////////////////////////////////////////////////////////////////////////////
  // Command classification
  logic [4:0] cl_code;
  logic cl_tr;
  logic cl_undef;
  logic cl_bc_ok;
  logic cl_ignore;
  logic cl_illegal;
  logic cl_data;
  logic [8:0] cl_desc;
  logic [15:0] cl_ctl;
  logic [8:0] cl_ptr;
  logic [8:0] cl_base;

  always_comb begin
    cl_code = cmd_i.word[4:0];
    cl_tr = cmd_i.word[CMD_TR_BIT];
    cl_undef = (!cl_tr && cl_code <= MC_LAST_MAX_NODATA) ||
               (!cl_tr && (cl_code == MC_VECTOR || cl_code == last_command_report_code ||
                           cl_code == selftest_word_report_code)) ||
               (cl_tr && (cl_code == MC_SYNC_DATA || cl_code == MC_SEL_SHUT ||
                          cl_code == MC_SEL_OVR));
    cl_bc_ok = cl_tr ? (cl_code == MC_SYNC ||
                        (cl_code >= MC_SELFTEST_INIT && cl_code <= MC_LAST_MAX_NODATA)) // [R7]
                     : (cl_code == MC_SYNC_DATA || cl_code == MC_SEL_SHUT || // [R9]
                        cl_code == MC_SEL_OVR || cl_code >= MC_RSVD_LO); // [R8]
    cl_ignore = cl_undef && r_ff.undef_inv; // [R11]
    cl_illegal = cmd_i.illegal_bit || (cmd_i.bcast && !cl_bc_ok); // [R13] [R14]
    cl_data = cl_code[4] && !cl_illegal; // [R1] [R2] [R12] [R14]
    cl_desc = {1'b0, cl_tr, cl_code, 2'b00};
    cl_ctl = mem_ff[cl_desc];
    // Ping-pong with select bit set uses second pointer; anything else uses the first
    cl_ptr = mem_ff[cl_desc + DESC_PTR_OFS +
                    9'((cl_ctl[CTL_PP_EN_BIT] && cl_ctl[CTL_PP_SEL_BIT]) ? 1 : 0)][8:0]; // [R5]
    cl_base = r_ff.simpl ? (cl_desc + DESC_PTR_OFS) : cl_ptr; // [R4] [R6]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic wr_is_mem;
  logic rd_is_mem;
  logic [15:0] wr_merged;
  logic [15:0] wr_old;
  logic [31:0] rd_val;
  logic rd_ok;
  logic is_idle;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.resp = '0;
    nxt_r.tx_valid = 1'b0;
    nxt_r.done = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    is_idle = (r_ff.state == ST_IDLE);
    case (r_ff.state)
      ST_IDLE: begin
        if (cmd_i.valid && !cl_ignore) begin
          nxt_r.code = cl_code;
          nxt_r.tr = cl_tr;
          nxt_r.bcast = cmd_i.bcast;
          nxt_r.illegal = cl_illegal;
          nxt_r.desc = cl_desc;
          nxt_r.base = cl_base;
          nxt_r.msg_err = cl_illegal; // [R13]
          nxt_r.store_data = cl_data && (!cl_tr || cl_code == last_command_report_code ||
                                         cl_code == selftest_word_report_code); // [R21]
          if (!(cl_tr && cl_code == last_command_report_code)) begin
            nxt_r.last_cmd = cmd_i.word;
          end
          nxt_r.state = ST_RESP;
        end
      end
      ST_RESP: begin
        nxt_r.resp.valid = 1'b1;
        nxt_r.resp.send_status = !r_ff.bcast; // [R1] [R10]
        nxt_r.resp.send_data = r_ff.code[4] && r_ff.tr && !r_ff.illegal && !r_ff.bcast; // [R3]
        nxt_r.resp.msg_error = r_ff.illegal; // [R13]
        // Dynamic bus control acceptance is never reported
        if (r_ff.code[4] && r_ff.tr && !r_ff.illegal) begin
          nxt_r.tx_valid = !r_ff.bcast;
          if (r_ff.code == last_command_report_code) begin
            nxt_r.tx_word = r_ff.last_cmd; // [R19]
          end else if (r_ff.code == selftest_word_report_code) begin
            nxt_r.tx_word = r_ff.alt_sel ? r_ff.selftest1 : r_ff.selftest0; // [R20]
          end else begin
            nxt_r.tx_word = mem_ff[r_ff.base + BUF_DATA_OFS]; // [R18]
          end
          nxt_r.data = nxt_r.tx_word;
        end
        nxt_r.state = (r_ff.code[4] && !r_ff.tr && !r_ff.illegal) ? ST_RXW : ST_WINFO; // [R2]
      end
      ST_RXW: begin
        if (rx_valid_i) begin
          nxt_r.data = rx_word_i; // [R2]
          nxt_r.state = ST_WINFO;
        end
      end
      ST_WINFO: begin
        mem_we = 1'b1; // [R16]
        mem_wa = r_ff.base + BUF_INFO_OFS;
        mem_wd = '0;
        mem_wd[MI_BCAST_BIT] = r_ff.bcast;
        mem_wd[MI_ERR_BIT] = r_ff.illegal;
        mem_wd[MI_TR_BIT] = r_ff.tr;
        mem_wd[4:0] = r_ff.code;
        nxt_r.state = ST_WTT;
      end
      ST_WTT: begin
        mem_we = 1'b1; // [R16]
        mem_wa = r_ff.base + BUF_TT_OFS;
        mem_wd = time_tag_i;
        nxt_r.state = r_ff.store_data ? ST_WDATA : ST_WCTL;
      end
      ST_WDATA: begin
        mem_we = 1'b1; // [R17] [R21]
        mem_wa = r_ff.base + BUF_DATA_OFS;
        mem_wd = r_ff.data;
        nxt_r.state = ST_WCTL;
      end
      ST_WCTL: begin
        mem_we = 1'b1;
        mem_wa = r_ff.desc;
        mem_wd = mem_ff[r_ff.desc];
        mem_wd[CTL_DBAC_BIT] = 1'b1;
        mem_wd[CTL_BCAST_BIT] = r_ff.bcast;
        if (!r_ff.simpl && mem_wd[CTL_PP_EN_BIT]) begin
          mem_wd[CTL_PP_SEL_BIT] = !mem_wd[CTL_PP_SEL_BIT]; // [R4] [R15]
        end
        nxt_r.done = 1'b1;
        nxt_r.state = ST_IDLE;
      end
      default: begin
        nxt_r.state = ST_IDLE;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write
    wr_idx = r_ff.aw_idx;
    wr_is_mem = (wr_idx >= IDX_MEM_BASE) && (32'(wr_idx - IDX_MEM_BASE) < MEM_DEPTH);
    wr_old = wr_is_mem ? mem_ff[9'(wr_idx - IDX_MEM_BASE)] : 16'h0000;
    case (wr_idx)
      IDX_SELFTEST0: wr_old = r_ff.selftest0;
      IDX_SELFTEST1: wr_old = r_ff.selftest1;
      default: wr_old = wr_old;
    endcase
    wr_merged[7:0] = r_ff.w_strb[0] ? r_ff.w_data[7:0] : wr_old[7:0];
    wr_merged[15:8] = r_ff.w_strb[1] ? r_ff.w_data[15:8] : wr_old[15:8];
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_r.aw_held = 1'b1;
      nxt_r.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_r.w_held = 1'b1;
      nxt_r.w_data = s_axi_wdata[15:0];
      nxt_r.w_strb = s_axi_wstrb[1:0];
    end
    if (r_ff.aw_held && r_ff.w_held && !r_ff.bvalid && (!wr_is_mem || is_idle)) begin
      nxt_r.aw_held = 1'b0;
      nxt_r.w_held = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = AXI_OKAY;
      if (wr_is_mem) begin
        mem_we = 1'b1;
        mem_wa = 9'(wr_idx - IDX_MEM_BASE);
        mem_wd = wr_merged;
      end else begin
        case (wr_idx)
          IDX_CFG1: begin
            if (r_ff.w_strb[0]) begin
              nxt_r.simpl = r_ff.w_data[CFG1_SIMPL_BIT];
              nxt_r.undef_inv = r_ff.w_data[CFG1_UNDEF_BIT];
            end
          end
          IDX_CFG2: begin
            if (r_ff.w_strb[0]) begin
              nxt_r.alt_sel = r_ff.w_data[CFG2_ALT_BIT];
            end
          end
          IDX_SELFTEST0: nxt_r.selftest0 = wr_merged;
          IDX_SELFTEST1: nxt_r.selftest1 = wr_merged;
          IDX_STATUS, IDX_LAST_CMD: nxt_r.bresp = AXI_OKAY;
          default: nxt_r.bresp = AXI_SLVERR;
        endcase
      end
    end
    if (r_ff.bvalid && s_axi_bready) begin
      nxt_r.bvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    rd_idx = s_axi_araddr[11:2];
    rd_is_mem = (rd_idx >= IDX_MEM_BASE) && (32'(rd_idx - IDX_MEM_BASE) < MEM_DEPTH);
    rd_ok = 1'b1;
    rd_val = '0;
    if (rd_is_mem) begin
      rd_val[15:0] = mem_ff[9'(rd_idx - IDX_MEM_BASE)];
    end else begin
      case (rd_idx)
        IDX_CFG1: begin
          rd_val[CFG1_SIMPL_BIT] = r_ff.simpl;
          rd_val[CFG1_UNDEF_BIT] = r_ff.undef_inv;
        end
        IDX_CFG2: rd_val[CFG2_ALT_BIT] = r_ff.alt_sel;
        IDX_STATUS: begin
          rd_val[STAT_MSGERR_BIT] = r_ff.msg_err;
          rd_val[STAT_BUSY_BIT] = !is_idle;
        end
        IDX_LAST_CMD: rd_val[15:0] = r_ff.last_cmd;
        IDX_SELFTEST0: rd_val[15:0] = r_ff.selftest0;
        IDX_SELFTEST1: rd_val[15:0] = r_ff.selftest1;
        default: rd_ok = 1'b0;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata = rd_val;
      nxt_r.rresp = rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (r_ff.rvalid && s_axi_rready) begin
      nxt_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_ff <= '0;
      r_ff.state <= ST_IDLE;
      r_ff.simpl <= CFG_SIMPL_RST;
      r_ff.undef_inv <= CFG_UNDEF_RST; // [R22]
      r_ff.alt_sel <= CFG_ALT_RST;
      r_ff.selftest0 <= SELFTEST_RST;
      r_ff.selftest1 <= SELFTEST_RST;
      r_ff.last_cmd <= LAST_CMD_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem_ff[mem_wa] <= mem_wd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rx_ready_o = (r_ff.state == ST_RXW);
  assign resp_o = r_ff.resp;
  assign tx_word_o = r_ff.tx_word;
  assign tx_valid_o = r_ff.tx_valid;
  assign done_o = r_ff.done;
  assign s_axi_awready = !r_ff.aw_held && !r_ff.bvalid;
  assign s_axi_wready = !r_ff.w_held && !r_ff.bvalid;
  assign s_axi_bvalid = r_ff.bvalid;
  assign s_axi_bresp = r_ff.bresp;
  assign s_axi_arready = !r_ff.rvalid && (is_idle || !rd_is_mem);
  assign s_axi_rvalid = r_ff.rvalid;
  assign s_axi_rdata = r_ff.rdata;
  assign s_axi_rresp = r_ff.rresp;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_undef_ignored: assert property ( // [R11]
    (r_ff.state == ST_IDLE && cmd_i.valid && cl_undef && r_ff.undef_inv)
      |=> (r_ff.state == ST_IDLE) ##1 !resp_o.valid)
    else $error("undefined command not ignored");
  a_nodata_low: assert property ( // [R1]
    (resp_o.valid && !r_ff.code[4]) |-> (!resp_o.send_data && !tx_valid_o))
    else $error("data sent for code below 16");
  a_tx_one_word: assert property ( // [R3]
    (resp_o.valid && resp_o.send_data) |-> tx_valid_o ##1 !tx_valid_o [*4])
    else $error("transmit data word count wrong");
  a_illegal_status: assert property ( // [R13]
    (r_ff.state == ST_IDLE && cmd_i.valid && !cl_ignore && cmd_i.illegal_bit)
      |=> r_ff.msg_err ##1 (resp_o.valid && resp_o.msg_error && !resp_o.send_data))
    else $error("illegal command response wrong");
  a_bcast_refused: assert property ( // [R7]
    (r_ff.state == ST_IDLE && cmd_i.valid && !cl_ignore && cmd_i.bcast && !cl_bc_ok)
      |=> r_ff.msg_err && r_ff.illegal)
    else $error("broadcast not refused");
  a_selftest_word: assert property ( // [R20]
    (tx_valid_o && r_ff.code == selftest_word_report_code)
      |-> tx_word_o == (r_ff.alt_sel ? r_ff.selftest1 : r_ff.selftest0))
    else $error("self-test word source wrong");
  a_last_cmd_word: assert property ( // [R19]
    (tx_valid_o && r_ff.code == last_command_report_code) |-> tx_word_o == r_ff.last_cmd)
    else $error("last command word wrong");
  a_rx_store: assert property ( // [R17]
    (r_ff.state == ST_RXW && rx_valid_i) |=> ##2
      (mem_we && mem_wa == r_ff.base + BUF_DATA_OFS && mem_wd == $past(rx_word_i, 3)))
    else $error("received word not stored");
  a_simpl_place: assert property ( // [R6]
    (r_ff.state == ST_WINFO && r_ff.simpl) |-> mem_wa == r_ff.desc + DESC_PTR_OFS)
    else $error("simplified storage address wrong");

endmodule : mcd_handler

// ---- tb/mcd_bc_model.sv ----
// Purpose: Bus controller model issuing one mode command at a time
// Assumes: caller waits for the previous message to finish
// Notes: released data line shows the inverse of the last word
`timescale 1ns/1ps
module mcd_bc_model (
  input wire logic sys_clk_i,
  input wire logic rx_ready_i,
  input wire mcd_pkg::mcd_resp_s resp_i,
  input wire logic [15:0] tx_word_i,
  input wire logic done_i,
  output mcd_pkg::mcd_cmd_s cmd_o,
  output logic rx_valid_o,
  output logic [15:0] rx_word_o
);
  import mcd_pkg::*;

  initial begin
    cmd_o = '0;
    rx_valid_o = 1'b0;
    rx_word_o = 16'hFFFF;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic [15:0] w, input logic b, input logic il,
      input logic [15:0] d, input int dly, output logic got, output mcd_resp_s r,
      output logic [15:0] tw);
    int n;
    got = 1'b0;
    r = '0;
    tw = '0;
    cmd_o <= '{valid: 1'b1, bcast: b, illegal_bit: il, word: w};
    @(posedge sys_clk_i);
    cmd_o.valid <= 1'b0;
    for (n = 0; n < 20 && got == 1'b0; n++) begin
      @(posedge sys_clk_i);
      if (resp_i.valid === 1'b1) begin
        got = 1'b1;
        r = resp_i;
        tw = tx_word_i;
      end
    end
    if (got && rx_ready_i === 1'b1) begin
      repeat (dly) @(posedge sys_clk_i);
      rx_word_o <= d;
      rx_valid_o <= 1'b1;
      @(posedge sys_clk_i);
      rx_valid_o <= 1'b0;
      rx_word_o <= ~d;
    end
    for (n = 0; n < 40 && got && done_i !== 1'b1; n++) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
  endtask : issue
endmodule : mcd_bc_model

// ---- tb/mode_command_data_handler_tb.sv ----
// Purpose: Self-checking bench for the mode command data handler
// Assumes: bench sets up all descriptors before traffic
// Notes: expected words derive from command fields
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module mode_command_data_handler_tb;
  import mcd_pkg::*;
  localparam logic [3:0] RS_TXD = 4'hE;
  localparam logic [3:0] RS_ST = 4'hC;
  localparam logic [3:0] RS_ERR = 4'hD;
  localparam logic [3:0] RS_NONE = 4'h0;
  localparam logic [9:0] BT [12] = '{10'h218, 10'h238, 10'h298, 10'h229, 10'h209, 10'h059,
    10'h148, 10'h329, 10'h198, 10'h399, 10'h118, 10'h309};
  logic sys_clk_i, nrst_i, rxv, rxr, txv, done;
  mcd_cmd_s cmd;
  mcd_resp_s resp;
  logic [15:0] tag, rxw, txw, tw;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_mismatch, num_checks, cyc, i, n_txv;

  mcd_handler DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_i(cmd), .time_tag_i(tag),
    .rx_valid_i(rxv), .rx_word_i(rxw), .rx_ready_o(rxr), .resp_o(resp), .tx_word_o(txw),
    .tx_valid_o(txv), .done_o(done), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  mcd_bc_model bc (.sys_clk_i(sys_clk_i), .rx_ready_i(rxr), .resp_i(resp), .tx_word_i(txw),
    .done_i(done), .cmd_o(cmd), .rx_valid_o(rxv), .rx_word_o(rxw));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (txv === 1'b1) begin
      n_txv++;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] cw(input logic tr, input logic [4:0] c);
    return {5'h05, tr, 5'h1F, c};
  endfunction : cw

  function automatic logic [11:0] maddr(input logic [8:0] n);
    return {1'b1, n, 2'b00};
  endfunction : maddr

  function automatic logic [8:0] bufp(input logic tr, input logic [4:0] c);
    return {1'b1, tr, c, 2'b00};
  endfunction : bufp

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk_i);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk_i); while (bvalid !== 1'b1);
    `CHK("bresp", AXI_OKAY, bresp)
    bready <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk_i); while (rvalid !== 1'b1);
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd_chk

  task automatic run(input logic tr, input logic [4:0] c, input logic b, input logic il,
      input logic [3:0] e);
    logic got;
    mcd_resp_s r;
    int t0;
    tag <= {11'h3D0, c};
    t0 = n_txv;
    bc.issue(cw(tr, c), b, il, {11'h680, c}, int'(c[1:0]), got, r, tw);
    `CHK("resp", e, {got, r.send_status, r.send_data, r.msg_error})
    `CHK("txv", int'(e[1]), n_txv - t0)
  endtask : run

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst_i = 1'b0;
    tag = 16'h0000;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_chk(12'h004, 32'h0, AXI_OKAY);
    rd_chk(12'h008, 32'h0, AXI_OKAY);
    rd_chk(12'h0F0, 32'h0, AXI_SLVERR);
    for (i = 0; i < 64; i++) begin
      wr(maddr({1'b0, i[5:0], 2'b00}), 16'h0000);
      wr(maddr({1'b0, i[5:0], 2'b01}), {7'h00, bufp(i[5], i[4:0])});
      wr(maddr(bufp(i[5], i[4:0]) + 9'h002), {10'h300, i[5:0]});
    end
    wr(12'h050, 16'h1234);
    wr(12'h054, 16'h5678);
    run(1'b1, 5'd1, 1'b0, 1'b0, RS_ST);
    rd_chk(maddr(bufp(1'b1, 5'd1)), 32'h0021, AXI_OKAY);
    rd_chk(maddr(bufp(1'b1, 5'd1) + 9'h001), 32'h7A01, AXI_OKAY);
    rd_chk(maddr(bufp(1'b1, 5'd1) + 9'h002), 32'hC021, AXI_OKAY);
    run(1'b1, 5'd0, 1'b0, 1'b0, RS_ST);
    run(1'b1, 5'd16, 1'b0, 1'b0, RS_TXD);
    `CHK("txw", 16'hC030, tw)
    run(1'b0, 5'd17, 1'b0, 1'b0, RS_ST);
    rd_chk(maddr(bufp(1'b0, 5'd17) + 9'h002), 32'hD011, AXI_OKAY);
    rd_chk(maddr(bufp(1'b0, 5'd17)), 32'h0011, AXI_OKAY);
    run(1'b1, 5'd19, 1'b0, 1'b0, RS_TXD);
    `CHK("txw", 16'h1234, tw)
    wr(12'h008, 16'h0001);
    run(1'b1, 5'd19, 1'b0, 1'b0, RS_TXD);
    `CHK("txw", 16'h5678, tw)
    rd_chk(maddr(bufp(1'b1, 5'd19) + 9'h002), 32'h5678, AXI_OKAY);
    run(1'b1, 5'd18, 1'b0, 1'b0, RS_TXD);
    `CHK("txw", cw(1'b1, 5'd19), tw)
    rd_chk(maddr(bufp(1'b1, 5'd18) + 9'h002), {16'h0, cw(1'b1, 5'd19)}, AXI_OKAY);
    run(1'b1, 5'd16, 1'b0, 1'b1, RS_ERR);
    rd_chk(12'h00C, 32'h1, AXI_OKAY);
    run(1'b1, 5'd22, 1'b0, 1'b0, RS_TXD);
    `CHK("txw", 16'hC036, tw)
    run(1'b0, 5'd22, 1'b0, 1'b1, RS_ERR);
    rd_chk(maddr(bufp(1'b0, 5'd22) + 9'h002), 32'hC016, AXI_OKAY);
    run(1'b1, 5'd17, 1'b0, 1'b0, RS_TXD);
    run(1'b0, 5'd16, 1'b0, 1'b0, RS_ST);
    rd_chk(maddr(bufp(1'b0, 5'd16) + 9'h002), 32'hD010, AXI_OKAY);
    for (i = 0; i < 12; i++) begin
      run(BT[i][9], BT[i][8:4], 1'b1, 1'b0, BT[i][3:0]);
    end
    wr(12'h004, 16'h0002);
    run(1'b0, 5'd5, 1'b0, 1'b0, RS_NONE);
    run(1'b1, 5'd17, 1'b0, 1'b0, RS_NONE);
    run(1'b0, 5'd18, 1'b0, 1'b0, RS_NONE);
    rd_chk(12'h00C, 32'h1, AXI_OKAY);
    run(1'b1, 5'd1, 1'b0, 1'b0, RS_ST);
    wr(12'h004, 16'h0001);
    run(1'b0, 5'd20, 1'b0, 1'b0, RS_ST);
    rd_chk(maddr({1'b0, 6'h14, 2'b11}), 32'hD014, AXI_OKAY);
    rd_chk(maddr({1'b0, 6'h14, 2'b01}), 32'h0014, AXI_OKAY);
    print_verdict();
  end
endmodule : mode_command_data_handler_tb
